// ==== src/cms_consts.svh ====
// Constants for the clock mode sequencer
`ifndef CMS_CONSTS_SVH
`define CMS_CONSTS_SVH
`define CMS_ADDR_CTRL 4'h0
`define CMS_ADDR_MULT 4'h4
`define CMS_ADDR_FILT 4'h8
`define CMS_ADDR_STAT 4'hc
`define CMS_REQ_SCM 2'h0
`define CMS_REQ_FEI 2'h1
`define CMS_REQ_FBE 2'h2
`define CMS_REQ_FEE 2'h3
`define CMS_CTRL_REQ_LO 0
`define CMS_CTRL_REFSEL 2
`define CMS_CTRL_RANGE 3
`define CMS_CTRL_DBG 4
`define CMS_CTRL_OSCKEEP 5
`define CMS_CTRL_DIV_LO 8
`define CMS_MULT_RST 3'h0
`define CMS_DIV_RST 3'h0
`define CMS_FILT_RST 12'h0c0
`define CMS_XTAL_CLOCKS 13'h1000
`define CMS_LOCK_SAMPLES 4'h4
`define CMS_AVG_CYCLES 2'h3
`define CMS_STAT_MODE_LO 0
`define CMS_STAT_LOCKED 2
`define CMS_STAT_OSC_ST 3
`define CMS_STAT_EXT_REFERENCE_STATUS 4
`define CMS_STAT_LOSS 5
`define CMS_STAT_EXTDOUBLE 6
`endif

// ==== src/cms_pkg.sv ====
// Types for the clock mode sequencer
package cms_pkg;
	typedef enum logic [1:0] {
		CMS_SCM,
		CMS_FEI,
		CMS_FBE,
		CMS_FEE
	} cms_mode_t;
	typedef enum {
		CMS_ST_RUN,
		CMS_ST_OFF,
		CMS_ST_WAIT_EXT
	} cms_phase_t;
endpackage

// ==== src/cms_clock_mode_sequencer.sv ====
// Clock mode sequencer with Wishbone registers
//
// Chosen here: the register addresses and register access over Wishbone.
`include "cms_consts.svh"
module cms_clock_mode_sequencer #(
	parameter int LOCK_SAMPLES = 4,
	parameter int XTAL_CLOCKS = 4096
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// Wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [3:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// Stop controller
	input wire logic stop_in,
	input wire logic wake_irq_in,
	input wire logic wake_reset_in,
	// Analog status pins
	input wire logic oscillator_stable_flag_in,
	input wire logic ext_reference_status_in,
	input wire logic ref_loss_in,
	input wire logic osc_loss_in,
	input wire logic ext_ref_edge_in,
	input wire logic lock_in_window_in,
	input wire logic unlock_out_window_in,
	input wire logic compare_done_in,
	input wire logic [7:0] count_error_in,
	// Clock control
	output logic [1:0] mode_in_effect_out,
	output logic osc_enable_out,
	output logic irg_enable_out,
	output logic xtal_amp_enable_out,
	output logic xtal_range_out,
	output logic use_ext_ref_out,
	output logic feed_enable_out,
	output logic output_enable_out,
	output logic [7:0] divisor_out,
	output logic [11:0] filter_value_out,
	output logic filter_update_out
);
	logic s1_stop, s2_stop, s1_osc, s2_osc, s1_ext_reference_status, s2_ext_reference_status;
	logic s1_rl, s2_rl, s1_ol, s2_ol, s1_edge, s2_edge, edge_d;
	logic s1_lw, s2_lw, s1_uw, s2_uw, s1_cd, s2_cd, cd_d;
	logic [7:0] s1_err, s2_err;
	logic [1:0] mode_request;
	logic reference_select, xtal_range, debug_in_stop_enable, oscillator_keep_in_stop;
	logic [2:0] div_sel, loop_multiplier_field;
	logic [11:0] filter_value;
	cms_pkg::cms_mode_t mode, next_mode;
	cms_pkg::cms_phase_t phase;
	logic locked, ever_locked, ext_double, clock_loss_flag, xtal_ready;
	logic [12:0] xtal_count;
	logic [3:0] lock_count;
	logic [1:0] avg_count;
	logic [9:0] err_sum;
	logic wr, rd_ok, cd_pulse, edge_pulse;

	// Two-flop synchronisers for pin inputs
	always_ff @(posedge clock_in) begin
		s1_stop <= stop_in;
		s2_stop <= s1_stop;
		s1_osc <= oscillator_stable_flag_in;
		s2_osc <= s1_osc;
		s1_ext_reference_status <= ext_reference_status_in;
		s2_ext_reference_status <= s1_ext_reference_status;
		s1_rl <= ref_loss_in;
		s2_rl <= s1_rl;
		s1_ol <= osc_loss_in;
		s2_ol <= s1_ol;
		s1_edge <= ext_ref_edge_in;
		s2_edge <= s1_edge;
		edge_d <= s2_edge;
		s1_lw <= lock_in_window_in;
		s2_lw <= s1_lw;
		s1_uw <= unlock_out_window_in;
		s2_uw <= s1_uw;
		s1_cd <= compare_done_in;
		s2_cd <= s1_cd;
		cd_d <= s2_cd;
		s1_err <= count_error_in;
		s2_err <= s1_err;
	end
	assign cd_pulse = s2_cd & ~cd_d;
	assign edge_pulse = s2_edge & ~edge_d;

	function automatic logic [7:0] cms_div(input logic [2:0] sel);
		cms_div = 8'h01 << sel;
	endfunction

	assign wr = wb_cyc_in & wb_stb_in & wb_we_in & ~wb_ack_out & wb_sel_in[0];
	assign rd_ok = wb_cyc_in & wb_stb_in & ~wb_ack_out;

	// Wishbone answer, one wait state
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0;
		end else begin
			wb_ack_out <= rd_ok;
			wb_dat_out <= 32'h0;
			if (rd_ok && !wb_we_in) begin
				case (wb_adr_in)
					`CMS_ADDR_CTRL: wb_dat_out <= {21'h0, div_sel, 2'h0,
						oscillator_keep_in_stop, debug_in_stop_enable,
						xtal_range, reference_select, mode_request};
					`CMS_ADDR_MULT: wb_dat_out <= {29'h0, loop_multiplier_field};
					`CMS_ADDR_FILT: wb_dat_out <= {20'h0, filter_value};
					`CMS_ADDR_STAT: wb_dat_out <= {25'h0, ext_double, clock_loss_flag,
						s2_ext_reference_status, s2_osc, locked, mode};
					default: wb_dat_out <= 32'h0;
				endcase
			end
		end
	end

	// Control register; reset wake restores defaults
	always_ff @(posedge clock_in) begin
		if (!resetn_in || wake_reset_in) begin
			mode_request <= `CMS_REQ_SCM;
			reference_select <= 1'b0;
			xtal_range <= 1'b0;
			debug_in_stop_enable <= 1'b0;
			oscillator_keep_in_stop <= 1'b0;
			div_sel <= `CMS_DIV_RST;
			loop_multiplier_field <= `CMS_MULT_RST;
		end else if (wr && wb_adr_in == `CMS_ADDR_CTRL) begin
			mode_request <= wb_dat_in[`CMS_CTRL_REQ_LO +: 2];
			reference_select <= wb_dat_in[`CMS_CTRL_REFSEL];
			xtal_range <= wb_dat_in[`CMS_CTRL_RANGE];
			debug_in_stop_enable <= wb_dat_in[`CMS_CTRL_DBG];
			oscillator_keep_in_stop <= wb_dat_in[`CMS_CTRL_OSCKEEP];
			div_sel <= wb_dat_in[`CMS_CTRL_DIV_LO +: 3];
		end else if (wr && wb_adr_in == `CMS_ADDR_MULT) begin
			loop_multiplier_field <= wb_dat_in[2:0];
		end else if (phase == cms_pkg::CMS_ST_RUN && next_mode == cms_pkg::CMS_SCM
			&& ((mode == cms_pkg::CMS_FEE && s2_rl)
			|| ((mode == cms_pkg::CMS_FEE || mode == cms_pkg::CMS_FBE)
			&& clock_loss_flag && !s2_ext_reference_status))) begin
			// Only a lost clock rewrites the request, never a software change
			mode_request <= `CMS_REQ_SCM;
		end else if (phase == cms_pkg::CMS_ST_RUN && mode == cms_pkg::CMS_FEE
			&& next_mode == cms_pkg::CMS_FBE) begin
			mode_request <= `CMS_REQ_FBE;
		end
	end

	// Mode selection while running
	always_comb begin
		next_mode = mode;
		case (mode)
			cms_pkg::CMS_SCM: begin
				if (mode_request == `CMS_REQ_FEI && s2_osc)
					next_mode = cms_pkg::CMS_FEI;
				else if (mode_request == `CMS_REQ_FEE && s2_osc && s2_ext_reference_status && xtal_ready)
					next_mode = cms_pkg::CMS_FEE;
				else if (mode_request == `CMS_REQ_FBE && s2_ext_reference_status && xtal_ready)
					next_mode = cms_pkg::CMS_FBE;
			end
			cms_pkg::CMS_FEI: begin
				if (mode_request != `CMS_REQ_FEI)
					next_mode = cms_pkg::CMS_SCM;
			end
			cms_pkg::CMS_FBE: begin
				if (clock_loss_flag && !s2_ext_reference_status)
					next_mode = cms_pkg::CMS_SCM;
				else if (mode_request != `CMS_REQ_FBE)
					next_mode = cms_pkg::CMS_SCM;
			end
			cms_pkg::CMS_FEE: begin
				if (s2_rl || (clock_loss_flag && !s2_ext_reference_status))
					next_mode = cms_pkg::CMS_SCM;
				else if (s2_ol && s2_ext_reference_status)
					next_mode = cms_pkg::CMS_FBE;
				else if (mode_request != `CMS_REQ_FEE)
					next_mode = cms_pkg::CMS_SCM;
			end
			default: next_mode = cms_pkg::CMS_SCM;
		endcase
	end

	// Stop sequencing and mode register
	always_ff @(posedge clock_in) begin
		if (!resetn_in || wake_reset_in) begin
			mode <= cms_pkg::CMS_SCM;
			phase <= cms_pkg::CMS_ST_RUN;
			ext_double <= 1'b0;
		end else begin
			case (phase)
				cms_pkg::CMS_ST_RUN: begin
					if (s2_stop && !debug_in_stop_enable) begin
						phase <= cms_pkg::CMS_ST_OFF;
					end else begin
						mode <= next_mode;
						if (mode == cms_pkg::CMS_FEE && next_mode == cms_pkg::CMS_SCM)
							ext_double <= ~ever_locked;
						else if (next_mode != cms_pkg::CMS_SCM)
							ext_double <= 1'b0;
					end
				end
				cms_pkg::CMS_ST_OFF: begin
					if (wake_irq_in) begin
						if (mode_request == `CMS_REQ_FBE && s2_ext_reference_status) begin
							mode <= cms_pkg::CMS_FBE;
							phase <= cms_pkg::CMS_ST_WAIT_EXT;
						end else begin
							mode <= cms_pkg::CMS_SCM;
							phase <= cms_pkg::CMS_ST_RUN;
						end
					end
				end
				cms_pkg::CMS_ST_WAIT_EXT: begin
					if (xtal_ready)
						phase <= cms_pkg::CMS_ST_RUN;
				end
				default: phase <= cms_pkg::CMS_ST_RUN;
			endcase
		end
	end

	// Crystal start-up count
	always_ff @(posedge clock_in) begin
		if (!resetn_in || wake_reset_in || phase == cms_pkg::CMS_ST_OFF
			|| !mode_request[1]) begin
			xtal_count <= 13'h0;
			xtal_ready <= 1'b0;
		end else if (!reference_select) begin
			xtal_ready <= 1'b1;
		end else if (edge_pulse && !xtal_ready) begin
			if (xtal_count == 13'(XTAL_CLOCKS - 1))
				xtal_ready <= 1'b1;
			xtal_count <= xtal_count + 13'h1;
		end
	end

	// Clock loss flag, cleared by reset or by writing one to its status bit
	always_ff @(posedge clock_in) begin
		if (!resetn_in || wake_reset_in)
			clock_loss_flag <= 1'b0;
		else if (s2_rl || s2_ol)
			clock_loss_flag <= 1'b1;
		else if (wr && wb_adr_in == `CMS_ADDR_STAT && wb_dat_in[`CMS_STAT_LOSS])
			clock_loss_flag <= 1'b0;
	end

	// Lock detection and filter averaging
	always_ff @(posedge clock_in) begin
		if (!resetn_in || wake_reset_in || phase != cms_pkg::CMS_ST_RUN
			|| next_mode != mode || !(mode == cms_pkg::CMS_FEI
			|| mode == cms_pkg::CMS_FEE)) begin
			locked <= 1'b0;
			lock_count <= 4'h0;
			avg_count <= 2'h0;
			err_sum <= 10'h0;
			filter_update_out <= 1'b0;
			if (!resetn_in || next_mode != mode)
				ever_locked <= 1'b0;
		end else begin
			filter_update_out <= 1'b0;
			if (cd_pulse) begin
				if (!locked) begin
					if (s2_lw) begin
						if (lock_count == 4'(LOCK_SAMPLES - 1))
							locked <= 1'b1;
						lock_count <= lock_count + 4'h1;
					end else begin
						lock_count <= 4'h0;
					end
				end else if (s2_uw) begin
					locked <= 1'b0;
					lock_count <= 4'h0;
				end else begin
					avg_count <= avg_count + 2'h1;
					err_sum <= (avg_count == 2'h0) ? {{2{s2_err[7]}}, s2_err}
						: err_sum + {{2{s2_err[7]}}, s2_err};
					if (avg_count == `CMS_AVG_CYCLES)
						filter_update_out <= 1'b1;
				end
				if (locked)
					ever_locked <= 1'b1;
			end
		end
	end

	// Filter value, writable in self-clocked mode only
	always_ff @(posedge clock_in) begin
		if (!resetn_in || wake_reset_in)
			filter_value <= `CMS_FILT_RST;
		else if (wr && wb_adr_in == `CMS_ADDR_FILT && mode == cms_pkg::CMS_SCM)
			filter_value <= wb_dat_in[11:0];
		else if (filter_update_out)
			filter_value <= filter_value + {{4{err_sum[9]}}, err_sum[9:2]};
	end

	// Registered clock control outputs
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			mode_in_effect_out <= `CMS_REQ_SCM;
			osc_enable_out <= 1'b1;
			irg_enable_out <= 1'b1;
			xtal_amp_enable_out <= 1'b0;
			xtal_range_out <= 1'b0;
			use_ext_ref_out <= 1'b0;
			feed_enable_out <= 1'b1;
			output_enable_out <= 1'b1;
			divisor_out <= 8'h01;
			filter_value_out <= `CMS_FILT_RST;
		end else begin
			mode_in_effect_out <= mode;
			// Off: all sources stop unless kept in stop
			osc_enable_out <= (phase != cms_pkg::CMS_ST_OFF || oscillator_keep_in_stop)
				&& mode != cms_pkg::CMS_FBE;
			irg_enable_out <= (phase != cms_pkg::CMS_ST_OFF || oscillator_keep_in_stop)
				&& mode != cms_pkg::CMS_FBE;
			xtal_amp_enable_out <= reference_select && mode_request[1]
				&& (phase != cms_pkg::CMS_ST_OFF || oscillator_keep_in_stop);
			xtal_range_out <= xtal_range;
			use_ext_ref_out <= (mode == cms_pkg::CMS_FEE || mode == cms_pkg::CMS_FBE)
				&& phase == cms_pkg::CMS_ST_RUN;
			feed_enable_out <= phase == cms_pkg::CMS_ST_RUN;
			output_enable_out <= phase == cms_pkg::CMS_ST_RUN;
			// Extra halving until first lock; widest divisor saturates at 128
			if (mode == cms_pkg::CMS_FEE && !ever_locked) begin
				if (div_sel == 3'h7)
					divisor_out <= 8'h80;
				else
					divisor_out <= cms_div(div_sel) << 1;
			end else begin
				// Self-clocked uses the plain divisor, so output doubles after an FEE that never locked
				divisor_out <= cms_div(div_sel);
			end
			filter_value_out <= filter_value;
		end
	end
endmodule

// ==== bench/cms_props.sv ====
// Assertions for the clock mode sequencer
module cms_props (
	// Clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// Bus
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [3:0] wb_adr_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic wb_ack_out,
	// Clock control
	input wire logic [1:0] mode_in_effect_out,
	input wire logic osc_enable_out,
	input wire logic irg_enable_out,
	input wire logic [7:0] divisor_out,
	input wire logic [11:0] filter_value_out,
	input wire logic filter_update_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!resetn_in);
	wire logic req = wb_cyc_in && wb_stb_in && !wb_ack_out;
	property p_ack;
		req |=> wb_ack_out ##1 !wb_ack_out;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle");
	property p_rst;
		$rose(resetn_in) |-> mode_in_effect_out == 2'h0 && divisor_out == 8'h01
			&& filter_value_out == 12'h0c0;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_div;
		$onehot(divisor_out);
	endproperty
	a_div: assert property (p_div) else $error("divisor not power of two");
	property p_fbe;
		mode_in_effect_out == 2'h2 && $stable(mode_in_effect_out) |-> !osc_enable_out
			&& !irg_enable_out;
	endproperty
	a_fbe: assert property (p_fbe) else $error("sources on in bypass");
	property p_filt;
		req && wb_we_in && wb_adr_in == 4'h8 && mode_in_effect_out == 2'h2
			|=> $stable(filter_value_out) [*2];
	endproperty
	a_filt: assert property (p_filt) else $error("filter written in bypass");
	property p_wdat;
		wb_ack_out && $past(wb_we_in) |-> wb_dat_out == 32'h0;
	endproperty
	a_wdat: assert property (p_wdat) else $error("data on write");
	property p_stat;
		wb_ack_out && !$past(wb_we_in) && $past(wb_adr_in) == 4'hc
			|-> wb_dat_out[1:0] == mode_in_effect_out;
	endproperty
	a_stat: assert property (p_stat) else $error("status mode wrong");
	property p_upd;
		filter_update_out |-> mode_in_effect_out[0] ##1 !filter_update_out;
	endproperty
	a_upd: assert property (p_upd) else $error("bad filter update");
	c_fbe: cover property (mode_in_effect_out == 2'h2);
	c_fee: cover property (mode_in_effect_out == 2'h3);
	c_upd: cover property (filter_update_out);
endmodule
bind cms_clock_mode_sequencer cms_props cms_props_inst (.clock_in, .resetn_in,
	.wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out,
	.mode_in_effect_out, .osc_enable_out, .irg_enable_out, .divisor_out,
	.filter_value_out, .filter_update_out);

// ==== bench/cms_ext_source.sv ====
// Model of the external reference source
module cms_ext_source (
	// Clock and control
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic lose_in,
	// Status pins
	output logic stable_out,
	output logic ext_reference_status_out,
	output logic edge_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt, warm;
	// Toggle every 13 cycles, under 10 MHz
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			cnt <= 4'h0;
			edge_out <= 1'b0;
		end else if (!lose_in) begin
			cnt <= (cnt == 4'hc) ? 4'h0 : cnt + 4'h1;
			edge_out <= (cnt == 4'hc) ? !edge_out : edge_out;
		end
	end
	// Oscillator settles after reset
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			warm <= 4'h0;
		end else if (warm != 4'hf) begin
			warm <= warm + 4'h1;
		end
	end
	assign stable_out = warm == 4'hf;
	assign ext_reference_status_out = !lose_in;
endmodule

// ==== bench/tb_clock_mode_sequencer.sv ====
// Testbench for the clock mode sequencer
module tb_clock_mode_sequencer;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock_in = 1'b0;
	logic resetn_in = 1'b0;
	logic cyc = 0, stb = 0, we = 0, stop = 0, irq = 0, wrst = 0, lock = 0, lose = 0;
	logic oloss = 1'b0, unlk = 1'b0;
	logic [7:0] cerr = 8'h00;
	logic [3:0] adr = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [31:0] rd, rdat;
	logic ack, stab, ext_reference_status, redge, osc, internal_ref_generator, feed, oen, upd, xamp, xrng, uext;
	logic [1:0] mode;
	logic [7:0] div;
	logic [11:0] filt;
	int num_errors = 0;
	int tests_run = 0;
	always #2 clock_in = !clock_in;
	cms_clock_mode_sequencer #(.LOCK_SAMPLES(4), .XTAL_CLOCKS(8)) cms_clock_mode_sequencer_inst (
		.clock_in, .resetn_in, .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
		.wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(dat), .wb_dat_out(rdat),
		.wb_ack_out(ack), .stop_in(stop), .wake_irq_in(irq), .wake_reset_in(wrst),
		.oscillator_stable_flag_in(stab), .ext_reference_status_in(ext_reference_status),
		.ref_loss_in(lose), .osc_loss_in(oloss), .ext_ref_edge_in(redge),
		.lock_in_window_in(lock), .unlock_out_window_in(unlk), .compare_done_in(redge),
		.count_error_in(cerr), .mode_in_effect_out(mode), .osc_enable_out(osc),
		.irg_enable_out(internal_ref_generator), .xtal_amp_enable_out(xamp), .xtal_range_out(xrng),
		.use_ext_ref_out(uext), .feed_enable_out(feed), .output_enable_out(oen),
		.divisor_out(div), .filter_value_out(filt), .filter_update_out(upd));
	cms_ext_source cms_ext_source_inst (.clock_in, .resetn_in, .lose_in(lose),
		.stable_out(stab), .ext_reference_status_out(ext_reference_status), .edge_out(redge));
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clock_in);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) num_errors++;
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clock_in);
	endtask
	task automatic wm(input logic [1:0] m);
		int n;
		n = 0;
		while (mode !== m && n < 400) begin
			@(posedge clock_in);
			n++;
		end
		repeat (2) @(posedge clock_in);
		chk("mode", 32'(mode), 32'(m));
	endtask
	task automatic wf(input logic v);
		int n;
		n = 0;
		while (feed !== v && n < 400) begin
			@(posedge clock_in);
			n++;
		end
		chk("feed", 32'(feed), 32'(v));
	endtask
	task automatic t_reset;
		chk("div", 32'(div), 32'h1);
		chk("filt", 32'(filt), 32'h0c0);
		wm(2'h0);
		wb(1'b0, 4'hc, 32'h0);
		chk("stat", rd & 32'h3, 32'h0);
	endtask
	task automatic t_scm;
		wb(1'b1, 4'h8, 32'h123);
		wb(1'b0, 4'h8, 32'h0);
		chk("filt", rd, 32'h123);
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, 4'h0, 32'(i) << 8);
			repeat (3) @(posedge clock_in);
			chk("div", 32'(div), 32'h1 << i);
		end
		wb(1'b1, 4'h0, 32'h0);
	endtask
	task automatic t_fei;
		int n;
		n = 0;
		wb(1'b1, 4'h0, 32'h1);
		wm(2'h1);
		wb(1'b0, 4'hc, 32'h0);
		chk("lock", rd & 32'h4, 32'h0);
		wb(1'b1, 4'h8, 32'h456);
		wb(1'b0, 4'h8, 32'h0);
		chk("filt", rd, 32'h123);
		lock <= 1'b1;
		cerr <= 8'h08;
		while (upd !== 1'b1 && n < 900) begin
			@(posedge clock_in);
			n++;
		end
		chk("upd", 32'(upd), 32'h1);
		wb(1'b0, 4'h8, 32'h0);
		chk("avg", rd, 32'h12b);
		cerr <= 8'h00;
		wb(1'b0, 4'hc, 32'h0);
		chk("lock", rd & 32'h4, 32'h4);
		lock <= 1'b0;
		unlk <= 1'b1;
		repeat (40) @(posedge clock_in);
		wb(1'b0, 4'hc, 32'h0);
		chk("unlock", rd & 32'h4, 32'h0);
		unlk <= 1'b0;
		wb(1'b1, 4'h0, 32'h0);
		wm(2'h0);
	endtask
	task automatic t_ext;
		wb(1'b1, 4'h0, 32'h2);
		wm(2'h2);
		chk("src", 32'({osc, internal_ref_generator}), 32'h0);
		wb(1'b1, 4'h8, 32'h777);
		chk("filt", 32'(filt), 32'h12b);
		wb(1'b1, 4'h0, 32'h3);
		wm(2'h3);
		chk("div", 32'(div), 32'h2);
		oloss <= 1'b1;
		wm(2'h2);
		wb(1'b0, 4'h0, 32'h0);
		chk("req", rd & 32'h3, 32'h2);
		oloss <= 1'b0;
		repeat (3) @(posedge clock_in);
		wb(1'b1, 4'h0, 32'h3);
		wm(2'h3);
		lose <= 1'b1;
		wm(2'h0);
		chk("div", 32'(div), 32'h1);
		wb(1'b0, 4'h0, 32'h0);
		chk("req", rd & 32'h3, 32'h0);
		wb(1'b0, 4'hc, 32'h0);
		chk("dbl", rd & 32'h40, 32'h40);
		chk("loss", rd & 32'h20, 32'h20);
		lose <= 1'b0;
		repeat (3) @(posedge clock_in);
		wb(1'b1, 4'hc, 32'h20);
		wb(1'b0, 4'hc, 32'h0);
		chk("loss", rd & 32'h20, 32'h0);
	endtask
	task automatic t_wake;
		int n;
		n = 0;
		wb(1'b1, 4'h0, 32'he);
		wm(2'h2);
		chk("xamp", 32'({xamp, xrng, uext}), 32'h7);
		stop <= 1'b1;
		wf(1'b0);
		stop <= 1'b0;
		repeat (3) @(posedge clock_in);
		irq <= 1'b1;
		repeat (4) @(posedge clock_in);
		irq <= 1'b0;
		chk("oen", 32'({oen, uext}), 32'h0);
		while (oen !== 1'b1 && n < 600) begin
			@(posedge clock_in);
			n++;
		end
		chk("oen", 32'(oen), 32'h1);
		chk("mode", 32'(mode), 32'h2);
		wb(1'b1, 4'h0, 32'h3);
		wm(2'h3);
		stop <= 1'b1;
		wf(1'b0);
		stop <= 1'b0;
		repeat (3) @(posedge clock_in);
		irq <= 1'b1;
		wf(1'b1);
		irq <= 1'b0;
		chk("mode", 32'({mode, uext}), 32'h0);
		wm(2'h3);
	endtask
	task automatic t_stop;
		wb(1'b1, 4'h0, 32'h300);
		stop <= 1'b1;
		wf(1'b0);
		chk("osc", 32'(osc), 32'h0);
		stop <= 1'b0;
		repeat (3) @(posedge clock_in);
		irq <= 1'b1;
		wf(1'b1);
		irq <= 1'b0;
		chk("div", 32'(div), 32'h8);
		wb(1'b1, 4'h0, 32'h310);
		stop <= 1'b1;
		repeat (8) @(posedge clock_in);
		chk("feed", 32'(feed), 32'h1);
		stop <= 1'b0;
		repeat (3) @(posedge clock_in);
		wb(1'b1, 4'h0, 32'h320);
		stop <= 1'b1;
		wf(1'b0);
		chk("osc", 32'(osc), 32'h1);
		stop <= 1'b0;
		wrst <= 1'b1;
		repeat (3) @(posedge clock_in);
		wrst <= 1'b0;
		wm(2'h0);
		chk("div", 32'(div), 32'h1);
		chk("filt", 32'(filt), 32'h0c0);
		wb(1'b0, 4'h0, 32'h0);
		chk("ctrl", rd, 32'h0);
	endtask
	task automatic report_and_stop;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clock_in);
		resetn_in <= 1'b1;
		@(posedge clock_in);
		t_reset;
		t_scm;
		t_fei;
		t_ext;
		t_wake;
		t_stop;
		report_and_stop;
	end
	initial begin
		repeat (30000) @(posedge clock_in);
		num_errors++;
		report_and_stop;
	end
endmodule
